// [common/fcs_pkg.sv]
// Constants shared by the flash command front end and write sequencer
package fcs_pkg;

  // Register offsets on the software port
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_IRQ_FLAG = 2'h2;
  localparam logic [1:0] REG_IRQ_EN = 2'h3;

  // Control register fields
  localparam int CTRL_WE_BIT = 0;
  localparam int CTRL_SEQEN_BIT = 1;

  // Status register fields
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_PGM_BIT = 1;
  localparam int STAT_TMO_BIT = 2;
  localparam int STAT_PHASE_LSB = 4;

  // Flag and enable bit positions (same layout in both registers)
  localparam int FLG_IDLE = 0;
  localparam int FLG_DONE = 1;
  localparam int FLG_VFAIL = 2;
  localparam int FLG_WBUSY = 3;

  // Reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [3:0] FLAG_RST = 4'h0;
  localparam logic [3:0] IEN_RST = 4'h0;
  localparam logic [15:0] ERASED_WORD = 16'hffff;

  // Command codes carried on the low data byte
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_WRITE = 8'ha0;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_RESET = 8'hf0;

  // Array geometry
  localparam int WORDS = 16;

  // Timing: clock period, typical program time, maximum program time
  localparam int CLK_NS = 40;
  localparam int PROG_NS = 2000;
  localparam int PROG_MAX_NS = 8000;
  localparam logic [7:0] PROG_CYC = 8'((PROG_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] PROG_MAX_CYC = 8'(PROG_MAX_NS / CLK_NS);

  // Sequencer phase codes
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ISSUE = 2'b01,
    PH_CHECK = 2'b10
  } fcs_phase_t;

  // Flash core state
  typedef enum logic [1:0] {
    FL_READ = 2'b00,
    FL_PROG = 2'b01
  } fcs_fl_t;

endpackage

// [testbench/fcs_flash_cmd_seq_tb.sv]
// Self-checking testbench for the flash command front end and sequencer
`timescale 1ns/1ps
`default_nettype none

module fcs_flash_cmd_seq_tb;
  import fcs_pkg::*;
  logic clk, rst_b, reg_wr, reg_rd, fl_word, fl_wr, fl_rd, fl_stall;
  logic dma_clr, irq, dma_req, dma_stop;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, r;
  logic [4:0] fl_addr;
  logic [15:0] fl_wdata, fl_rdata, d, e;
  int n_mismatch, samples_checked, cycles;

  fcs_flash_cmd_seq u_dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
    .i_fl_addr(fl_addr), .i_fl_wdata(fl_wdata), .i_fl_word(fl_word), .i_fl_wr(fl_wr),
    .i_fl_rd(fl_rd), .o_fl_rdata(fl_rdata), .o_fl_stall(fl_stall), .i_dma_clr(dma_clr),
    .o_irq(irq), .o_dma_req(dma_req), .o_dma_stop(dma_stop));

  fcs_master_model u_mst (.i_ref_clk(clk), .i_fl_rdata(fl_rdata), .i_fl_stall(fl_stall),
    .o_fl_addr(fl_addr), .o_fl_wdata(fl_wdata), .o_fl_word(fl_word), .o_fl_wr(fl_wr),
    .o_fl_rd(fl_rd), .o_dma_clr(dma_clr));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic stop_test();
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Ceiling well above the longest path, two timeouts included
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic reg_check(input logic [1:0] a, input logic [7:0] exp);
    logic [7:0] v;
    reg_read(a, v);
    check({8'h00, v}, {8'h00, exp});
  endtask

  // Registered outputs load from next-state values, so they change on the causing edge itself
  task automatic settle();
    repeat (2) @(negedge clk);
  endtask

  task automatic poll_fl(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] v;
    int n;
    n = 0;
    do begin
      u_mst.fl_read(a, v);
      n++;
    end while (v !== exp && n < 100);
    check(v, exp);
  endtask

  task automatic wait_idle();
    logic [7:0] v;
    int n;
    n = 0;
    do begin
      reg_read(REG_STATUS, v);
      n++;
    end while (v[5:4] !== 2'b00 && n < 400);
    check(16'(v[5:4]), 16'(PH_IDLE));
  endtask

  task automatic send_prefix(input logic [7:0] c);
    u_mst.fl_cmd(CMD_UNLOCK1);
    u_mst.fl_cmd(CMD_UNLOCK2);
    u_mst.fl_cmd(c);
  endtask

  initial begin
    rst_b = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) reg_check(2'(i), (i == 1) ? 8'h01 : 8'h00);
    reg_write(REG_CTRL, 8'h01);
    u_mst.fl_cmd(CMD_UNLOCK1);
    u_mst.fl_read(5'h04, d);
    u_mst.fl_cmd(CMD_UNLOCK2);
    u_mst.fl_read(5'h06, d);
    u_mst.fl_cmd(CMD_WRITE);
    u_mst.fl_write(5'h02, 16'h1234);
    u_mst.fl_read(5'h02, d);
    u_mst.fl_read(5'h02, e);
    check(16'(d[6] ^ e[6]), 16'h0001);
    check(16'(d[7]), 16'h0001);
    u_mst.fl_cmd(CMD_RESET);
    poll_fl(5'h02, 16'h1234);
    u_mst.fl_read(5'h04, d);
    check(d, ERASED_WORD);
    send_prefix(CMD_RESET);
    u_mst.fl_cmd(CMD_WRITE);
    u_mst.fl_write(5'h06, 16'h0000);
    repeat (60) @(posedge clk);
    u_mst.fl_read(5'h06, d);
    check(d, ERASED_WORD);
    send_prefix(CMD_ERASE);
    u_mst.fl_cmd(CMD_UNLOCK1);
    u_mst.fl_cmd(CMD_RESET);
    send_prefix(CMD_WRITE);
    u_mst.fl_write(5'h06, 16'h5678);
    poll_fl(5'h06, 16'h5678);
    send_prefix(CMD_WRITE);
    u_mst.fl_byte(5'h05, 8'h3c);
    poll_fl(5'h04, 16'h3cff);
    // A zero bit asked to become one keeps the algorithm running
    send_prefix(CMD_WRITE);
    u_mst.fl_write(5'h02, 16'hffff);
    repeat (100) @(posedge clk);
    reg_read(REG_STATUS, r);
    check(16'(r[STAT_TMO_BIT]), 16'h0000);
    repeat (120) @(posedge clk);
    reg_read(REG_STATUS, r);
    check(16'(r[STAT_TMO_BIT]), 16'h0001);
    u_mst.fl_read(5'h02, d);
    check(16'({d[7], d[5]}), 16'h0001);
    send_prefix(CMD_RESET);
    reg_read(REG_STATUS, r);
    check(16'(r[STAT_TMO_BIT]), 16'h0000);
    poll_fl(5'h0e, ERASED_WORD);
    reg_write(REG_CTRL, 8'h03);
    reg_write(REG_IRQ_EN, 8'h0f);
    settle();
    check(16'({irq, dma_req}), 16'h0003);
    reg_check(REG_IRQ_FLAG, 8'h01);
    reg_write(REG_IRQ_FLAG, 8'h01);
    settle();
    check(16'(dma_req), 16'h0000);
    u_mst.fl_write(5'h08, 16'h00ff);
    settle();
    check(16'(fl_stall), 16'h0001);
    u_mst.fl_write(5'h0a, 16'h0000);
    reg_write(REG_CTRL, 8'h00);
    u_mst.fl_read(5'h08, d);
    reg_read(REG_STATUS, r);
    check(16'(r[5:4]), 16'(PH_CHECK));
    wait_idle();
    reg_check(REG_CTRL, 8'h03);
    reg_check(REG_IRQ_FLAG, 8'h0b);
    check(16'({irq, dma_stop}), 16'h0003);
    poll_fl(5'h08, 16'h00ff);
    u_mst.fl_read(5'h0a, d);
    check(d, ERASED_WORD);
    u_mst.dma_clear();
    settle();
    reg_check(REG_IRQ_FLAG, 8'h08);
    reg_write(REG_IRQ_EN, 8'h02);
    reg_write(REG_IRQ_FLAG, 8'h0f);
    u_mst.fl_write(5'h08, 16'hffff);
    wait_idle();
    reg_check(REG_IRQ_FLAG, 8'h05);
    check(16'({irq, dma_stop}), 16'h0000);
    reg_write(REG_IRQ_EN, 8'h04);
    settle();
    check(16'({irq, dma_stop}), 16'h0003);
    reg_write(REG_CTRL, 8'h02);
    reg_write(REG_IRQ_FLAG, 8'h0f);
    u_mst.fl_write(5'h0c, 16'h0000);
    settle();
    reg_read(REG_IRQ_FLAG, r);
    check(16'(r[3:2]), 16'h0000);
    u_mst.fl_read(5'h0c, d);
    check(d, ERASED_WORD);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    reg_check(REG_CTRL, 8'h00);
    reg_check(REG_IRQ_FLAG, 8'h00);
    stop_test();
  end
endmodule

`default_nettype wire

// [testbench/fcs_master_model.sv]
// Bus master model driving the flash port and the DMA clear strobe
`timescale 1ns/1ps
`default_nettype none

module fcs_master_model (
  // Clock
  input wire logic i_ref_clk,
  // Flash port answers
  input wire logic [15:0] i_fl_rdata,
  input wire logic i_fl_stall,
  // Flash port requests
  output logic [4:0] o_fl_addr,
  output logic [15:0] o_fl_wdata,
  output logic o_fl_word,
  output logic o_fl_wr,
  output logic o_fl_rd,
  output logic o_dma_clr
);
  initial begin
    o_fl_addr = 5'h00;
    o_fl_wdata = 16'h0000;
    o_fl_word = 1'b1;
    o_fl_wr = 1'b0;
    o_fl_rd = 1'b0;
    o_dma_clr = 1'b0;
  end

  // Always word writes, so the byte lane bit is forced to zero
  task automatic fl_write(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    o_fl_addr <= {a[4:1], 1'b0};
    o_fl_wdata <= d;
    o_fl_wr <= 1'b1;
    @(posedge i_ref_clk);
    o_fl_wr <= 1'b0;
    o_fl_wdata <= ~d;
  endtask

  task automatic fl_cmd(input logic [7:0] c);
    fl_write(5'h00, {8'h00, c});
  endtask

  // Byte write; the lane is picked by the low address bit
  task automatic fl_byte(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    o_fl_addr <= a;
    o_fl_wdata <= {8'h00, d};
    o_fl_word <= 1'b0;
    o_fl_wr <= 1'b1;
    @(posedge i_ref_clk);
    o_fl_wr <= 1'b0;
    o_fl_word <= 1'b1;
  endtask

  // Stall is sampled mid-cycle so the taking edge is never raced
  task automatic fl_read(input logic [4:0] a, output logic [15:0] d);
    logic s;
    int n;
    n = 0;
    @(posedge i_ref_clk);
    o_fl_addr <= a;
    o_fl_rd <= 1'b1;
    do begin
      @(negedge i_ref_clk);
      s = i_fl_stall;
      @(posedge i_ref_clk);
      n++;
    end while (s && n < 200);
    o_fl_rd <= 1'b0;
    #1 d = i_fl_rdata;
  endtask

  task automatic dma_clear();
    @(posedge i_ref_clk);
    o_dma_clr <= 1'b1;
    @(posedge i_ref_clk);
    o_dma_clr <= 1'b0;
  endtask
endmodule

`default_nettype wire

// [verilog/fcs_flash_cmd_seq.sv]
// Flash command front end with write command sequencer
`timescale 1ns/1ps
`default_nettype none

module fcs_flash_cmd_seq
  import fcs_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Software register port
  input wire logic [1:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // Flash bus from the master
  input wire logic [4:0] i_fl_addr,
  input wire logic [15:0] i_fl_wdata,
  input wire logic i_fl_word,
  input wire logic i_fl_wr,
  input wire logic i_fl_rd,
  output logic [15:0] o_fl_rdata,
  output logic o_fl_stall,
  // Interrupt and DMA handshakes
  input wire logic i_dma_clr,
  output logic o_irq,
  output logic o_dma_req,
  output logic o_dma_stop
);

  // Control and flag registers
  logic ctrl_we_q, ctrl_we_d, ctrl_seqen_q, ctrl_seqen_d;
  logic [3:0] flags_q, flags_d, ien_q, ien_d, flag_set;
  logic [7:0] reg_rdata_d;
  logic irq_q, dma_req_q, dma_stop_q;

  // Flash core state
  fcs_fl_t fl_q, fl_d;
  logic tmo_q, tmo_d, tog_q, tog_d, erase_q, erase_d;
  logic [2:0] seq_q, seq_d;
  logic [7:0] pcnt_q, pcnt_d;
  logic [3:0] tgt_idx_q, tgt_idx_d;
  logic [15:0] tgt_val_q, tgt_val_d, cur, fl_rdata_d;
  logic [15:0] mem_q [WORDS];
  logic fail, mem_we;

  // Sequencer state
  fcs_phase_t phase_q, phase_d;
  logic [1:0] sq_cnt_q, sq_cnt_d;
  logic sq_rst_q, sq_rst_d, sq_word_q, sq_word_d, stall_q;
  logic [4:0] sq_addr_q, sq_addr_d;
  logic [15:0] sq_data_q, sq_data_d;

  // Command path into the flash core
  logic dir_wr, seq_req, seq_take, busy_err, sq_wr, cmd_wr, cmd_word;
  logic [4:0] cmd_addr;
  logic [15:0] cmd_wdata;
  logic [7:0] cmd_code;
  logic rd_take;

  assign dir_wr = i_fl_wr && ctrl_we_q && !ctrl_seqen_q;
  assign seq_req = i_fl_wr && ctrl_we_q && ctrl_seqen_q;
  assign busy_err = seq_req && (phase_q != PH_IDLE);
  assign seq_take = seq_req && (phase_q == PH_IDLE);
  assign sq_wr = (phase_q == PH_ISSUE);
  // In sequencer mode only the sequencer reaches the core
  assign cmd_wr = dir_wr || sq_wr;
  assign rd_take = i_fl_rd && !stall_q;

  always_comb begin
    cmd_addr = i_fl_addr;
    cmd_wdata = i_fl_wdata;
    cmd_word = i_fl_word;
    if (sq_wr) begin
      cmd_addr = sq_addr_q;
      cmd_word = sq_word_q;
      case (sq_cnt_q)
        2'd0: cmd_wdata = {8'h00, CMD_UNLOCK1};
        2'd1: cmd_wdata = {8'h00, CMD_UNLOCK2};
        2'd2: cmd_wdata = {8'h00, sq_rst_q ? CMD_RESET : CMD_WRITE};
        default: cmd_wdata = sq_data_q;
      endcase
    end
  end
  assign cmd_code = cmd_wdata[7:0];

  // Flash core: command decoder and program algorithm
  assign cur = mem_q[tgt_idx_q];
  // Any target bit that would go 0 -> 1 keeps the algorithm from finishing
  assign fail = |(tgt_val_q & ~cur);

  always_comb begin
    fl_d = fl_q;
    tmo_d = tmo_q;
    tog_d = tog_q;
    erase_d = erase_q;
    seq_d = seq_q;
    pcnt_d = pcnt_q;
    tgt_idx_d = tgt_idx_q;
    tgt_val_d = tgt_val_q;
    mem_we = 1'b0;
    fl_rdata_d = o_fl_rdata;
    if (fl_q == FL_PROG && !tmo_q) begin
      pcnt_d = pcnt_q + 8'd1;
      if (!fail && pcnt_q == PROG_CYC - 8'd1) begin
        mem_we = 1'b1;
        fl_d = FL_READ;
      end else if (fail && pcnt_q == PROG_MAX_CYC - 8'd1) begin
        tmo_d = 1'b1;
      end
    end
    // Reads never touch seq_q, so a sequence survives them
    if (cmd_wr && (fl_q == FL_READ || tmo_q)) begin
      if (cmd_code == CMD_RESET) begin
        seq_d = 3'd0;
        erase_d = 1'b0;
        if (tmo_q && seq_q == 3'd2) begin
          tmo_d = 1'b0;
          fl_d = FL_READ;
        end
      end else begin
        case (seq_q)
          3'd0: seq_d = (cmd_code == CMD_UNLOCK1) ? 3'd1 : 3'd0;
          3'd1: seq_d = (cmd_code == CMD_UNLOCK2) ? 3'd2 : 3'd0;
          3'd2: begin
            seq_d = 3'd0;
            if (!tmo_q && (cmd_code == CMD_WRITE || cmd_code == CMD_ERASE)) begin
              seq_d = 3'd3;
              erase_d = (cmd_code == CMD_ERASE);
            end
          end
          3'd3: begin
            seq_d = 3'd0;
            if (erase_q) begin
              seq_d = (cmd_code == CMD_UNLOCK1) ? 3'd4 : 3'd0;
            end else begin
              // One byte or word per command, other lane left as ones
              fl_d = FL_PROG;
              pcnt_d = 8'd0;
              tgt_idx_d = cmd_addr[4:1];
              if (cmd_word) begin
                tgt_val_d = cmd_wdata;
              end else if (cmd_addr[0]) begin
                tgt_val_d = {cmd_wdata[7:0], 8'hff};
              end else begin
                tgt_val_d = {8'hff, cmd_wdata[7:0]};
              end
            end
          end
          3'd4: seq_d = (cmd_code == CMD_UNLOCK2) ? 3'd5 : 3'd0;
          // Erase execution is not built; the final cycle just closes it
          default: begin
            seq_d = 3'd0;
            erase_d = 1'b0;
          end
        endcase
      end
    end
    if (rd_take) begin
      if (fl_q == FL_PROG) begin
        // Polling bit is the complement of the data being written
        fl_rdata_d = {~tgt_val_q[15], tog_q, tmo_q, 5'h00,
                      ~tgt_val_q[7], tog_q, tmo_q, 5'h00};
        tog_d = ~tog_q;
      end else begin
        fl_rdata_d = mem_q[i_fl_addr[4:1]];
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fl_q <= FL_READ;
      tmo_q <= 1'b0;
      tog_q <= 1'b0;
      erase_q <= 1'b0;
      seq_q <= 3'd0;
      pcnt_q <= 8'd0;
      tgt_idx_q <= 4'h0;
      tgt_val_q <= ERASED_WORD;
      o_fl_rdata <= 16'h0000;
    end else begin
      fl_q <= fl_d;
      tmo_q <= tmo_d;
      tog_q <= tog_d;
      erase_q <= erase_d;
      seq_q <= seq_d;
      pcnt_q <= pcnt_d;
      tgt_idx_q <= tgt_idx_d;
      tgt_val_q <= tgt_val_d;
      o_fl_rdata <= fl_rdata_d;
    end
  end

  // Array cells; programming can only clear bits
  genvar gi;
  generate
    for (gi = 0; gi < WORDS; gi++) begin : g_cell
      always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          mem_q[gi] <= ERASED_WORD;
        end else if (mem_we && tgt_idx_q == 4'(gi)) begin
          mem_q[gi] <= mem_q[gi] & tgt_val_q;
        end
      end
    end
  endgenerate

  // Write command sequencer
  always_comb begin
    phase_d = phase_q;
    sq_cnt_d = sq_cnt_q;
    sq_rst_d = sq_rst_q;
    sq_addr_d = sq_addr_q;
    sq_data_d = sq_data_q;
    sq_word_d = sq_word_q;
    flag_set = 4'h0;
    flag_set[FLG_WBUSY] = busy_err;
    case (phase_q)
      PH_IDLE: begin
        if (seq_take) begin
          phase_d = PH_ISSUE;
          sq_cnt_d = 2'd0;
          sq_rst_d = 1'b0;
          sq_addr_d = i_fl_addr;
          sq_data_d = i_fl_wdata;
          sq_word_d = i_fl_word;
        end
      end
      PH_ISSUE: begin
        sq_cnt_d = sq_cnt_q + 2'd1;
        if (sq_rst_q && sq_cnt_q == 2'd2) begin
          phase_d = PH_IDLE;
          flag_set[FLG_IDLE] = 1'b1;
        end else if (sq_cnt_q == 2'd3) begin
          phase_d = PH_CHECK;
        end
      end
      PH_CHECK: begin
        if (tmo_q) begin
          // A stuck write is flushed by an internal reset sequence
          phase_d = PH_ISSUE;
          sq_cnt_d = 2'd0;
          sq_rst_d = 1'b1;
          flag_set[FLG_VFAIL] = 1'b1;
        end else if (fl_q == FL_READ) begin
          phase_d = PH_IDLE;
          flag_set[FLG_IDLE] = 1'b1;
          if (cur != tgt_val_q) begin
            flag_set[FLG_VFAIL] = 1'b1;
          end else begin
            flag_set[FLG_DONE] = 1'b1;
          end
        end
      end
      default: phase_d = PH_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      phase_q <= PH_IDLE;
      sq_cnt_q <= 2'd0;
      sq_rst_q <= 1'b0;
      sq_addr_q <= 5'h00;
      sq_data_q <= 16'h0000;
      sq_word_q <= 1'b0;
      stall_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      sq_cnt_q <= sq_cnt_d;
      sq_rst_q <= sq_rst_d;
      sq_addr_q <= sq_addr_d;
      sq_data_q <= sq_data_d;
      sq_word_q <= sq_word_d;
      stall_q <= (phase_d == PH_ISSUE);
    end
  end
  assign o_fl_stall = stall_q;

  // Software registers, flags and handshakes
  logic [3:0] flag_clr;

  always_comb begin
    ctrl_we_d = ctrl_we_q;
    ctrl_seqen_d = ctrl_seqen_q;
    ien_d = ien_q;
    flag_clr = 4'h0;
    reg_rdata_d = 8'h00;
    if (i_reg_wr) begin
      case (i_reg_addr)
        REG_CTRL: begin
          // Changing mode mid-write would strand the flash in a sequence
          if (phase_q == PH_IDLE) begin
            ctrl_we_d = i_reg_wdata[CTRL_WE_BIT];
            ctrl_seqen_d = i_reg_wdata[CTRL_SEQEN_BIT];
          end
        end
        REG_IRQ_FLAG: flag_clr = i_reg_wdata[3:0];
        REG_IRQ_EN: ien_d = i_reg_wdata[3:0];
        default: ;
      endcase
    end
    if (i_dma_clr) begin
      flag_clr[FLG_IDLE] = 1'b1;
      flag_clr[FLG_DONE] = 1'b1;
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        REG_CTRL: begin
          reg_rdata_d[CTRL_WE_BIT] = ctrl_we_q;
          reg_rdata_d[CTRL_SEQEN_BIT] = ctrl_seqen_q;
        end
        REG_STATUS: begin
          reg_rdata_d[STAT_READY_BIT] = (fl_q == FL_READ);
          reg_rdata_d[STAT_PGM_BIT] = (fl_q == FL_PROG);
          reg_rdata_d[STAT_TMO_BIT] = tmo_q;
          reg_rdata_d[STAT_PHASE_LSB +: 2] = phase_q;
        end
        REG_IRQ_FLAG: reg_rdata_d = {4'h0, flags_q};
        default: reg_rdata_d = {4'h0, ien_q};
      endcase
    end
    // Newly enabling the sequencer announces readiness
    if (ctrl_we_d && ctrl_seqen_d && !(ctrl_we_q && ctrl_seqen_q)) begin
      flag_clr[FLG_IDLE] = 1'b0;
    end
    // Set wins over a clear in the same cycle
    flags_d = (flags_q & ~flag_clr) | flag_set;
    if (ctrl_we_d && ctrl_seqen_d && !(ctrl_we_q && ctrl_seqen_q)) begin
      flags_d[FLG_IDLE] = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_we_q <= CTRL_RST[CTRL_WE_BIT];
      ctrl_seqen_q <= CTRL_RST[CTRL_SEQEN_BIT];
      flags_q <= FLAG_RST;
      ien_q <= IEN_RST;
      o_reg_rdata <= 8'h00;
      irq_q <= 1'b0;
      dma_req_q <= 1'b0;
      dma_stop_q <= 1'b0;
    end else begin
      ctrl_we_q <= ctrl_we_d;
      ctrl_seqen_q <= ctrl_seqen_d;
      flags_q <= flags_d;
      ien_q <= ien_d;
      o_reg_rdata <= reg_rdata_d;
      irq_q <= |(flags_d & ien_d);
      dma_req_q <= flags_d[FLG_IDLE] && ien_d[FLG_IDLE];
      dma_stop_q <= |(flags_d[FLG_WBUSY:FLG_VFAIL] & ien_d[FLG_WBUSY:FLG_VFAIL]);
    end
  end
  assign o_irq = irq_q;
  assign o_dma_req = dma_req_q;
  assign o_dma_stop = dma_stop_q;

  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  AST_WRITE_STARTS: assert property (
    cmd_wr && fl_q == FL_READ && !tmo_q && seq_q == 3'd3 && !erase_q
      && cmd_code != CMD_RESET |=> fl_q == FL_PROG)
    else $error("write did not start after fourth cycle");
  AST_PROG_DEAF: assert property (
    fl_q == FL_PROG && !tmo_q && cmd_wr |=> seq_q == $past(seq_q))
    else $error("command accepted during programming");
  AST_RESET_CANCELS: assert property (
    cmd_wr && fl_q == FL_READ && cmd_code == CMD_RESET |=> seq_q == 3'd0 && !erase_q)
    else $error("reset did not cancel sequence");
  AST_TMO_EXIT: assert property (
    tmo_q && cmd_wr && seq_q == 3'd2 && cmd_code == CMD_RESET |=> fl_q == FL_READ && !tmo_q)
    else $error("timeout not left by reset sequence");
  AST_NO_ONE_BACK: assert property (
    fl_q == FL_PROG && fail |=> mem_q[tgt_idx_q] == $past(cur)
      && (fl_q == FL_PROG || $past(tmo_q)))
    else $error("write of one over zero completed");
  AST_TMO_LIMIT: assert property (
    fl_q == FL_PROG && fail && !tmo_q && pcnt_q == PROG_MAX_CYC - 8'd1 |=> tmo_q)
    else $error("timeout flag late");
  AST_BUSY_FLAG: assert property (
    seq_req && phase_q != PH_IDLE |=> flags_q[FLG_WBUSY] && $stable(sq_addr_q) && $stable(sq_data_q))
    else $error("busy write not flagged");
  AST_SILENT_DROP: assert property (
    i_fl_wr && ctrl_seqen_q && !ctrl_we_q && phase_q == PH_IDLE
      |=> phase_q == PH_IDLE && !$rose(flags_q[FLG_WBUSY]))
    else $error("write without enable not dropped");
  AST_CTRL_LOCK: assert property (
    i_reg_wr && i_reg_addr == REG_CTRL && phase_q != PH_IDLE
      |=> $stable(ctrl_we_q) && $stable(ctrl_seqen_q))
    else $error("control changed while busy");
  AST_ISSUE_LEN: assert property (
    phase_q == PH_IDLE && seq_take |=> (phase_q == PH_ISSUE && o_fl_stall) [*4]
      ##1 phase_q == PH_CHECK && !o_fl_stall)
    else $error("issue phase length wrong");
  AST_IDLE_ON_EN: assert property (
    $rose(ctrl_we_q && ctrl_seqen_q) |-> flags_q[FLG_IDLE] ##1 o_irq == |(flags_q & ien_q))
    else $error("idle flag missing on enable");
  AST_TOGGLE: assert property (
    fl_q == FL_PROG && rd_take |=> tog_q != $past(tog_q))
    else $error("toggle bit did not flip");

endmodule

`default_nettype wire
